// ===== hw/tsm_cfg.svh
// register indices, field positions and reset values of the monitor
// Functional notes
// - flag status1 bit0 while internal temperature above its upper limit
// - flag status1 bit1 while internal temperature at or below lower limit
// - flag status1 bit2 while external temperature above its upper limit
// - flag status1 bit3 while external temperature at or below lower limit
// - flag status1 bit4 on an open or shorted remote sensor diode
// - flag status2 bit4 while supply above upper or at/below lower limit
// - any set status bit may drive the interrupt output active
// - reading a status register clears only flags whose condition has gone
// - software reset clears both status registers
// - combined low register: internal LSBs in 1:0, supply LSBs in 3:2
// - external low register holds external LSBs in 1:0, rest zero
// - supply high register holds supply MSBs, loaded by each measurement
// - internal high register holds internal MSBs, twos complement
// - external high register holds external MSBs, twos complement
// - status and result registers reset to zero
// - channel 0 low byte is read/write and forms the code with high byte
// - channel 0 high byte at next index is read/write, resets to zero
`ifndef TSM_CFG_SVH
`define TSM_CFG_SVH
`define TSM_IDX_FLAGS_TEMP  10'h000
`define TSM_IDX_FLAGS_SUP   10'h001
`define TSM_IDX_LOW_BITS    10'h003
`define TSM_IDX_EXT_LOW     10'h004
`define TSM_IDX_SUP_HIGH    10'h006
`define TSM_IDX_INT_HIGH    10'h007
`define TSM_IDX_EXT_HIGH    10'h008
`define TSM_IDX_DAC_LOW     10'h010
`define TSM_IDX_DAC_HIGH    10'h011
`define TSM_IDX_MASK_TEMP   10'h030
`define TSM_IDX_MASK_SUP    10'h031
`define TSM_IDX_CONTROL     10'h032
`define TSM_SUP_FLAG_BIT    4
`define TSM_SOFT_RST_BIT    0
`define TSM_MASK_TEMP_RST   5'h1F
`define TSM_MASK_SUP_RST    1'h1
`define TSM_RESP_OKAY       2'h0
`define TSM_RESP_SLVERR     2'h2
`endif

// ===== hw/tsm_limit_cmp.sv
// compares each new measurement with its limits and holds the outcome
`timescale 1ns/10ps
`default_nettype none
module tsm_limit_cmp (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // measurements in, conditions out
    tsm_meas_if.cmp  m
);
    import tsm_pkg::*;
    typedef struct packed {
        tsm_cond_type cond;
    } tsm_cmp_state_type;
    tsm_cmp_state_type st;
    tsm_cmp_state_type next_st;

    always_comb begin
        next_st = st;
        if (m.valid) begin
            next_st.cond.int_hi = $signed(m.int_temp[9:2])
                                > $signed(m.lim.int_upper);
            next_st.cond.int_lo = $signed(m.int_temp[9:2])
                               <= $signed(m.lim.int_lower);
            next_st.cond.ext_hi = $signed(m.ext_temp[9:2])
                                > $signed(m.lim.ext_upper);
            next_st.cond.ext_lo = $signed(m.ext_temp[9:2])
                               <= $signed(m.lim.ext_lower);
            next_st.cond.sup_out = (m.supply[9:2] > m.lim.sup_upper)
                                 | (m.supply[9:2] <= m.lim.sup_lower);
        end else if (m.clear) begin
            next_st.cond = '0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign m.cond = st.cond;
endmodule : tsm_limit_cmp
`default_nettype wire

// ===== hw/tsm_meas_if.sv
// measurement and limit-condition carrier between readout and comparator
`timescale 1ns/10ps
`default_nettype none
interface tsm_meas_if;
    import tsm_pkg::*;
    logic            valid;
    logic            clear;
    tsm_reading_type int_temp;
    tsm_reading_type ext_temp;
    tsm_reading_type supply;
    tsm_limits_type  lim;
    tsm_cond_type    cond;
    modport src (output valid, clear, int_temp, ext_temp, supply, lim,
                 input cond);
    modport cmp (input valid, clear, int_temp, ext_temp, supply, lim,
                 output cond);
endinterface : tsm_meas_if
`default_nettype wire

// ===== hw/tsm_pin_sync.sv
// three-stage synchroniser for an asynchronous pin with agreement filter
`timescale 1ns/10ps
`default_nettype none
module tsm_pin_sync (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // pin in, filtered level out
    input wire logic pin,
    output logic     level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } tsm_sync_state_type;
    tsm_sync_state_type st;
    tsm_sync_state_type next_st;

    always_comb begin
        next_st = st;
        next_st.s1 = pin;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        // s1 only feeds s2 and is never compared; only agreeing later stages count
        if (st.s2 == st.s3) begin
            next_st.level = st.s3;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level = st.level;
endmodule : tsm_pin_sync
`default_nettype wire

// ===== hw/tsm_pkg.sv
// shared types of the monitor status block
package tsm_pkg;
    typedef logic [9:0] tsm_reading_type;
    typedef struct packed {
        logic sup_out;
        logic ext_lo;
        logic ext_hi;
        logic int_lo;
        logic int_hi;
    } tsm_cond_type;
    typedef struct packed {
        logic [7:0] int_upper;
        logic [7:0] int_lower;
        logic [7:0] ext_upper;
        logic [7:0] ext_lower;
        logic [7:0] sup_upper;
        logic [7:0] sup_lower;
    } tsm_limits_type;
    typedef enum logic [3:0] {
        TSM_REG_FLAGS_TEMP = 4'h0,
        TSM_REG_FLAGS_SUP  = 4'h1,
        TSM_REG_LOW_BITS   = 4'h2,
        TSM_REG_EXT_LOW    = 4'h3,
        TSM_REG_SUP_HIGH   = 4'h4,
        TSM_REG_INT_HIGH   = 4'h5,
        TSM_REG_EXT_HIGH   = 4'h6,
        TSM_REG_DAC_LOW    = 4'h7,
        TSM_REG_DAC_HIGH   = 4'h8,
        TSM_REG_MASK_TEMP  = 4'h9,
        TSM_REG_MASK_SUP   = 4'hA,
        TSM_REG_CONTROL    = 4'hB,
        TSM_REG_NONE       = 4'hC
    } tsm_reg_type;
endpackage : tsm_pkg

// ===== hw/tsm_status_regs.sv
// status, result and channel-0 code registers behind an AXI4-Lite slave
`timescale 1ns/10ps
`default_nettype none
`include "tsm_cfg.svh"
module tsm_status_regs (
    // clock and reset
    input wire logic             aclk,
    input wire logic             aresetn,
    // write address and data
    input wire logic [11:0]      awaddr,
    input wire logic             awvalid,
    output logic                 awready,
    input wire logic [31:0]      wdata,
    input wire logic [3:0]       wstrb,
    input wire logic             wvalid,
    output logic                 wready,
    // write response
    output logic [1:0]           bresp,
    output logic                 bvalid,
    input wire logic             bready,
    // read address and data
    input wire logic [11:0]      araddr,
    input wire logic             arvalid,
    output logic                 arready,
    output logic [31:0]          rdata,
    output logic [1:0]           rresp,
    output logic                 rvalid,
    input wire logic             rready,
    // converter results, same clock
    input wire logic             meas_valid,
    input wire tsm_pkg::tsm_reading_type int_temp,
    input wire tsm_pkg::tsm_reading_type ext_temp,
    input wire tsm_pkg::tsm_reading_type supply,
    // limit values from the limit bank
    input wire tsm_pkg::tsm_limits_type  limits,
    // remote diode fault detector, asynchronous
    input wire logic             diode_fault,
    // interrupt and channel-0 code
    output logic                 irq,
    output logic [11:0]          dac_code
);
    import tsm_pkg::*;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        aw_got;
        logic        w_got;
        logic [9:0]  widx;
        logic [7:0]  wdata;
        logic        wstb;
        logic        sw_rst;
        logic [4:0]  flags1;
        logic        flags2;
        logic [4:0]  mask1;
        logic        mask2;
        logic [7:0]  int_hi;
        logic [1:0]  int_lo;
        logic [7:0]  ext_hi;
        logic [1:0]  ext_lo;
        logic [7:0]  sup_hi;
        logic [1:0]  sup_lo;
        logic [7:0]  dac_hi;
        logic [3:0]  dac_lo;
        logic        irq;
    } tsm_state_type;

    tsm_state_type st;
    tsm_state_type next_st;
    logic          fault_level;

    tsm_meas_if m ();

    function automatic tsm_reg_type reg_decode(input logic [9:0] idx);
        case (idx)
            `TSM_IDX_FLAGS_TEMP: reg_decode = TSM_REG_FLAGS_TEMP;
            `TSM_IDX_FLAGS_SUP:  reg_decode = TSM_REG_FLAGS_SUP;
            `TSM_IDX_LOW_BITS:   reg_decode = TSM_REG_LOW_BITS;
            `TSM_IDX_EXT_LOW:    reg_decode = TSM_REG_EXT_LOW;
            `TSM_IDX_SUP_HIGH:   reg_decode = TSM_REG_SUP_HIGH;
            `TSM_IDX_INT_HIGH:   reg_decode = TSM_REG_INT_HIGH;
            `TSM_IDX_EXT_HIGH:   reg_decode = TSM_REG_EXT_HIGH;
            `TSM_IDX_DAC_LOW:    reg_decode = TSM_REG_DAC_LOW;
            `TSM_IDX_DAC_HIGH:   reg_decode = TSM_REG_DAC_HIGH;
            `TSM_IDX_MASK_TEMP:  reg_decode = TSM_REG_MASK_TEMP;
            `TSM_IDX_MASK_SUP:   reg_decode = TSM_REG_MASK_SUP;
            `TSM_IDX_CONTROL:    reg_decode = TSM_REG_CONTROL;
            default:             reg_decode = TSM_REG_NONE;
        endcase
    endfunction : reg_decode

    tsm_pin_sync u_fault_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     (diode_fault),
        .level   (fault_level)
    );

    tsm_limit_cmp u_cmp (
        .aclk    (aclk),
        .aresetn (aresetn),
        .m       (m.cmp)
    );

    assign m.valid    = meas_valid;
    assign m.clear    = st.sw_rst;
    assign m.int_temp = int_temp;
    assign m.ext_temp = ext_temp;
    assign m.supply   = supply;
    assign m.lim      = limits;

    always_comb begin
        logic [4:0]  set1;
        logic [4:0]  clr1;
        logic        clr2;
        tsm_reg_type rk;
        tsm_reg_type wk;
        next_st = st;
        next_st.sw_rst = 1'b0;
        set1 = {fault_level, m.cond[3:0]};
        clr1 = '0;
        clr2 = 1'b0;
        rk = reg_decode(araddr[11:2]);
        wk = reg_decode(st.widx);

        // read channel
        if (st.rvalid && rready) begin
            next_st.rvalid  = 1'b0;
            next_st.arready = 1'b1;
        end
        if (arvalid && st.arready) begin
            next_st.arready = 1'b0;
            next_st.rvalid  = 1'b1;
            next_st.rdata   = '0;
            next_st.rresp   = `TSM_RESP_OKAY;
            unique case (rk)
                TSM_REG_FLAGS_TEMP: begin
                    next_st.rdata[4:0] = st.flags1;
                    clr1 = ~set1;
                end
                TSM_REG_FLAGS_SUP: begin
                    next_st.rdata[`TSM_SUP_FLAG_BIT] = st.flags2;
                    clr2 = ~m.cond.sup_out;
                end
                TSM_REG_LOW_BITS:
                    next_st.rdata[3:0] = {st.sup_lo, st.int_lo};
                TSM_REG_EXT_LOW:
                    next_st.rdata[1:0] = st.ext_lo;
                TSM_REG_SUP_HIGH:  next_st.rdata[7:0] = st.sup_hi;
                TSM_REG_INT_HIGH:  next_st.rdata[7:0] = st.int_hi;
                TSM_REG_EXT_HIGH:  next_st.rdata[7:0] = st.ext_hi;
                TSM_REG_DAC_LOW:
                    next_st.rdata[7:0] = {st.dac_lo, 4'h0};
                TSM_REG_DAC_HIGH:  next_st.rdata[7:0] = st.dac_hi;
                TSM_REG_MASK_TEMP: next_st.rdata[4:0] = st.mask1;
                TSM_REG_MASK_SUP:
                    next_st.rdata[`TSM_SUP_FLAG_BIT] = st.mask2;
                TSM_REG_CONTROL:   next_st.rdata = '0;
                TSM_REG_NONE:      next_st.rresp = `TSM_RESP_SLVERR;
            endcase
        end

        // write channels, taken in either order
        if (st.bvalid && bready) begin
            next_st.bvalid  = 1'b0;
            next_st.awready = 1'b1;
            next_st.wready  = 1'b1;
        end
        if (awvalid && st.awready) begin
            next_st.aw_got  = 1'b1;
            next_st.awready = 1'b0;
            next_st.widx    = awaddr[11:2];
        end
        if (wvalid && st.wready) begin
            next_st.w_got  = 1'b1;
            next_st.wready = 1'b0;
            next_st.wdata  = wdata[7:0];
            next_st.wstb   = wstrb[0];
        end
        if (st.aw_got && st.w_got) begin
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = `TSM_RESP_OKAY;
            unique case (wk)
                TSM_REG_FLAGS_TEMP:
                    if (st.wstb) clr1 = clr1 | st.wdata[4:0];
                TSM_REG_FLAGS_SUP:
                    if (st.wstb) clr2 = clr2 | st.wdata[`TSM_SUP_FLAG_BIT];
                TSM_REG_DAC_LOW:
                    if (st.wstb) next_st.dac_lo = st.wdata[7:4];
                TSM_REG_DAC_HIGH:
                    if (st.wstb) next_st.dac_hi = st.wdata;
                TSM_REG_MASK_TEMP:
                    if (st.wstb) next_st.mask1 = st.wdata[4:0];
                TSM_REG_MASK_SUP:
                    if (st.wstb) next_st.mask2 = st.wdata[`TSM_SUP_FLAG_BIT];
                TSM_REG_CONTROL:
                    if (st.wstb) next_st.sw_rst = st.wdata[`TSM_SOFT_RST_BIT];
                TSM_REG_LOW_BITS, TSM_REG_EXT_LOW, TSM_REG_SUP_HIGH,
                TSM_REG_INT_HIGH, TSM_REG_EXT_HIGH: ;
                TSM_REG_NONE: next_st.bresp = `TSM_RESP_SLVERR;
            endcase
        end

        // a live condition re-sets in the same cycle, so set beats a read or write clear; software reset beats set
        next_st.flags1 = (st.flags1 & ~clr1) | set1;
        next_st.flags2 = (st.flags2 & ~clr2) | m.cond.sup_out;
        if (st.sw_rst) begin
            next_st.flags1 = '0;
            next_st.flags2 = 1'b0;
        end

        // results only move on a fresh conversion
        if (meas_valid) begin
            next_st.int_hi = int_temp[9:2];
            next_st.int_lo = int_temp[1:0];
            next_st.ext_hi = ext_temp[9:2];
            next_st.ext_lo = ext_temp[1:0];
            next_st.sup_hi = supply[9:2];
            next_st.sup_lo = supply[1:0];
        end

        next_st.irq = (|(next_st.flags1 & next_st.mask1))
                    | (next_st.flags2 & next_st.mask2);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st         <= '0;
            st.awready <= 1'b1;
            st.wready  <= 1'b1;
            st.arready <= 1'b1;
            st.mask1   <= `TSM_MASK_TEMP_RST;
            st.mask2   <= `TSM_MASK_SUP_RST;
        end else begin
            st <= next_st;
        end
    end

    assign awready  = st.awready;
    assign wready   = st.wready;
    assign bresp    = st.bresp;
    assign bvalid   = st.bvalid;
    assign arready  = st.arready;
    assign rdata    = st.rdata;
    assign rresp    = st.rresp;
    assign rvalid   = st.rvalid;
    assign irq      = st.irq;
    assign dac_code = {st.dac_hi, st.dac_lo};

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic rd_temp;
    logic rd_low;
    logic wr_dac_lo;
    logic wr_int_hi;
    assign rd_temp   = arvalid && st.arready && rk_is(TSM_REG_FLAGS_TEMP);
    assign rd_low    = arvalid && st.arready && rk_is(TSM_REG_LOW_BITS);
    assign wr_dac_lo = st.aw_got && st.w_got && st.wstb
                    && reg_decode(st.widx) == TSM_REG_DAC_LOW;
    assign wr_int_hi = st.aw_got && st.w_got
                    && reg_decode(st.widx) == TSM_REG_INT_HIGH;

    function automatic logic rk_is(input tsm_reg_type r);
        rk_is = reg_decode(araddr[11:2]) == r;
    endfunction : rk_is

    sequence live_cond(int b);
        m.cond[b] && !st.sw_rst;
    endsequence

    int_hi_flag_a: assert property (live_cond(0) |=> st.flags1[0])
        else $error("internal upper flag not set");
    int_lo_flag_a: assert property (live_cond(1) |=> st.flags1[1])
        else $error("internal lower flag not set");
    ext_hi_flag_a: assert property (live_cond(2) |=> st.flags1[2])
        else $error("external upper flag not set");
    ext_lo_flag_a: assert property (live_cond(3) |=> st.flags1[3])
        else $error("external lower flag not set");
    diode_fault_a: assert property (fault_level && !st.sw_rst
        |=> st.flags1[4])
        else $error("diode fault flag not set");
    supply_flag_a: assert property (live_cond(4) |=> st.flags2)
        else $error("supply flag not set");
    irq_level_a: assert property (irq == ((|(st.flags1 & st.mask1))
        | (st.flags2 & st.mask2)))
        else $error("interrupt does not follow flags");
    read_clear_a: assert property (rd_temp && !fault_level
        && m.cond[3:0] == 4'h0 && !(st.aw_got && st.w_got)
        |=> st.flags1 == 5'h00 && (!irq || st.flags2))
        else $error("read did not clear corrected flags");
    soft_reset_a: assert property (st.sw_rst
        |=> st.flags1 == 5'h00 && !st.flags2)
        else $error("software reset left flags set");
    low_bits_a: assert property (rd_low && !meas_valid
        |=> rvalid && rdata == {28'h0000000, $past(st.sup_lo),
                                $past(st.int_lo)})
        else $error("combined low register wrong");
    dac_low_a: assert property (wr_dac_lo
        |=> dac_code[3:0] == $past(st.wdata[7:4]) && bvalid)
        else $error("channel 0 low byte not written");
    ro_ignore_a: assert property (wr_int_hi && !meas_valid
        |=> $stable(st.int_hi))
        else $error("read-only result was written");
    bvalid_hold_a: assert property (bvalid && !bready |=> bvalid)
        else $error("write response dropped early");

    sequence ar_taken;
        arvalid && arready;
    endsequence

    sequence r_answer;
        rvalid && !arready;
    endsequence

    read_answer_a: assert property (ar_taken |=> r_answer)
        else $error("read answer late");
    rvalid_hold_a: assert property (rvalid && !rready |=> rvalid
        && $stable(rdata))
        else $error("read data dropped early");
    write_answer_a: assert property (awvalid && awready && wvalid
        && wready |=> !awready ##1 bvalid)
        else $error("write answer late");
    flag_hold_a: assert property (!rd_temp && !st.sw_rst
        && !(st.aw_got && st.w_got)
        |=> (st.flags1 & $past(st.flags1)) == $past(st.flags1))
        else $error("temperature flag lost without read");
    sup_hold_a: assert property (st.flags2 && !st.sw_rst
        && !(arvalid && arready) && !(st.aw_got && st.w_got)
        |=> st.flags2)
        else $error("supply flag lost without read");
endmodule : tsm_status_regs
`default_nettype wire

// ===== tb/test_tsm_status_regs.sv
// self-checking bench of the monitor status registers
`timescale 1ns/10ps
`default_nettype none
`include "tsm_cfg.svh"
module test_tsm_status_regs;
    import tsm_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq, go, diode_fault;
    logic meas_valid;
    logic [11:0] awaddr, araddr, dac_code;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    tsm_reading_type int_v, ext_v, sup_v, int_temp, ext_temp, supply;
    tsm_limits_type  limits;
    int err_count, n_compared;
    localparam logic [7:0] int_m [4] = '{8'h21, 8'h20, 8'hF0, 8'hF1};
    localparam logic [7:0] ext_m [4] = '{8'h05, 8'h00, 8'h11, 8'h10};
    localparam logic [7:0] sup_m [4] = '{8'h80, 8'h40, 8'hC1, 8'hC0};
    localparam logic [7:0] exp_t [4] = '{8'h01, 8'h08, 8'h06, 8'h00};
    localparam logic [7:0] exp_s [4] = '{8'h00, 8'h10, 8'h10, 8'h00};
    localparam logic [9:0] rst_i [12] = '{10'h000, 10'h001, 10'h003,
        10'h004, 10'h006, 10'h007, 10'h008, 10'h010, 10'h011, 10'h030,
        10'h031, 10'h032};
    localparam logic [7:0] rst_v [12] = '{8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1F, 8'h10, 8'h00};

    tsm_sensor_model tsm_sensor_model_i (.aclk(aclk), .go(go),
        .int_v(int_v), .ext_v(ext_v), .sup_v(sup_v),
        .meas_valid(meas_valid), .int_temp(int_temp),
        .ext_temp(ext_temp), .supply(supply));
    tsm_status_regs tsm_status_regs_i (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .meas_valid(meas_valid), .int_temp(int_temp),
        .ext_temp(ext_temp), .supply(supply), .limits(limits),
        .diode_fault(diode_fault), .irq(irq), .dac_code(dac_code));

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    task end_sim;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim

    task chk_val(input string what, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : chk_val

    task chk_resp(input string what, input logic [1:0] e, g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : chk_resp

    task timed_out;
        err_count++;
        $display("MISMATCH bus wait expected answer seen none");
        end_sim();
    endtask : timed_out

    // both channels offered together, each dropped once taken
    task axi_write(input logic [9:0] i, input logic [7:0] d,
                   output logic [1:0] resp);
        int n;
        @(posedge aclk);
        awaddr  <= {i, 2'b00};
        wdata   <= {24'h000000, d};
        wstrb   <= 4'hF;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        if (n == 50) timed_out();
        resp = bresp;
        bready <= 1'b0;
    endtask : axi_write

    task axi_read(input logic [9:0] i, output logic [31:0] d,
                  output logic [1:0] resp);
        int n;
        @(posedge aclk);
        araddr  <= {i, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        if (n == 50) timed_out();
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : axi_read

    task rd_chk(input logic [9:0] i, input logic [7:0] e, input string w);
        logic [31:0] d;
        logic [1:0]  rs;
        axi_read(i, d, rs);
        chk_val(w, {24'h000000, e}, d);
        chk_resp(w, `TSM_RESP_OKAY, rs);
    endtask : rd_chk

    // low bits fixed so the split across registers is visible
    task meas(input int k);
        @(posedge aclk);
        go    <= 1'b1;
        int_v <= {int_m[k], 2'b01};
        ext_v <= {ext_m[k], 2'b10};
        sup_v <= {sup_m[k], 2'b11};
        @(posedge aclk);
        go <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask : meas

    initial begin
        logic [31:0] d;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, go} = '0;
        {awaddr, araddr, wdata, wstrb, int_v, ext_v, sup_v} = '0;
        diode_fault = 1'b0;
        limits = {8'h20, 8'hF0, 8'h10, 8'h00, 8'hC0, 8'h40};
        err_count = 0;
        n_compared = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        for (int k = 0; k < 12; k++)
            rd_chk(rst_i[k], rst_v[k], "reset value");
        $display("test reset values done");
        for (int k = 0; k < 4; k++) begin
            meas(k);
            rd_chk(`TSM_IDX_FLAGS_TEMP,
                exp_t[k] | (k > 0 ? exp_t[k-1] : 8'h00), "temp flags first");
            rd_chk(`TSM_IDX_FLAGS_TEMP, exp_t[k], "temp flags");
            rd_chk(`TSM_IDX_FLAGS_SUP,
                exp_s[k] | (k > 0 ? exp_s[k-1] : 8'h00), "supply flags first");
            rd_chk(`TSM_IDX_FLAGS_SUP, exp_s[k], "supply flags");
            chk_val("irq", {31'h0, (exp_t[k] | exp_s[k]) != 8'h00},
                {31'h0, irq});
            rd_chk(`TSM_IDX_INT_HIGH, int_m[k], "int high");
            rd_chk(`TSM_IDX_EXT_HIGH, ext_m[k], "ext high");
            rd_chk(`TSM_IDX_SUP_HIGH, sup_m[k], "supply high");
        end
        rd_chk(`TSM_IDX_LOW_BITS, 8'h0D, "low bits");
        rd_chk(`TSM_IDX_EXT_LOW, 8'h02, "ext low");
        $display("test limits and results done");
        axi_write(`TSM_IDX_INT_HIGH, 8'h55, r);
        chk_resp("result write", `TSM_RESP_OKAY, r);
        rd_chk(`TSM_IDX_INT_HIGH, 8'hF1, "int high kept");
        axi_write(10'h020, 8'h55, r);
        chk_resp("unmapped write", `TSM_RESP_SLVERR, r);
        axi_read(10'h020, d, r);
        chk_val("unmapped read", 32'h00000000, d);
        chk_resp("unmapped read", `TSM_RESP_SLVERR, r);
        axi_write(`TSM_IDX_DAC_LOW, 8'hA5, r);
        axi_write(`TSM_IDX_DAC_HIGH, 8'h3C, r);
        rd_chk(`TSM_IDX_DAC_LOW, 8'hA0, "dac low");
        rd_chk(`TSM_IDX_DAC_HIGH, 8'h3C, "dac high");
        chk_val("dac code", 32'h000003CA, {20'h0, dac_code});
        $display("test access kinds done");
        meas(0);
        chk_val("irq set", 32'h1, {31'h0, irq});
        axi_write(`TSM_IDX_MASK_TEMP, 8'h00, r);
        chk_val("irq masked", 32'h0, {31'h0, irq});
        axi_write(`TSM_IDX_MASK_TEMP, 8'h1F, r);
        chk_val("irq unmasked", 32'h1, {31'h0, irq});
        meas(1);
        axi_write(`TSM_IDX_MASK_TEMP, 8'h00, r);
        chk_val("irq supply only", 32'h1, {31'h0, irq});
        axi_write(`TSM_IDX_MASK_SUP, 8'h00, r);
        chk_val("irq supply masked", 32'h0, {31'h0, irq});
        meas(3);
        axi_write(`TSM_IDX_FLAGS_SUP, 8'h10, r);
        axi_write(`TSM_IDX_MASK_SUP, 8'h10, r);
        chk_val("irq write clear", 32'h0, {31'h0, irq});
        axi_write(`TSM_IDX_MASK_TEMP, 8'h1F, r);
        chk_val("irq temp sticky", 32'h1, {31'h0, irq});
        meas(2);
        axi_write(`TSM_IDX_CONTROL, 8'h01, r);
        repeat (3) @(posedge aclk);
        rd_chk(`TSM_IDX_FLAGS_TEMP, 8'h00, "soft reset temp");
        rd_chk(`TSM_IDX_FLAGS_SUP, 8'h00, "soft reset supply");
        chk_val("irq after soft reset", 32'h0, {31'h0, irq});
        $display("test interrupt and soft reset done");
        diode_fault <= 1'b1;
        repeat (10) @(posedge aclk);
        rd_chk(`TSM_IDX_FLAGS_TEMP, 8'h10, "fault flag");
        diode_fault <= 1'b0;
        repeat (10) @(posedge aclk);
        rd_chk(`TSM_IDX_FLAGS_TEMP, 8'h10, "fault sticky");
        rd_chk(`TSM_IDX_FLAGS_TEMP, 8'h00, "fault cleared");
        chk_val("irq idle", 32'h0, {31'h0, irq});
        $display("test diode fault done");
        end_sim();
    end
endmodule : test_tsm_status_regs
`default_nettype wire

// ===== tb/tsm_sensor_model.sv
// converter model that posts one set of readings per bench request
`timescale 1ns/10ps
`default_nettype none
module tsm_sensor_model (
    // clock
    input wire logic             aclk,
    // request from the bench
    input wire logic             go,
    input wire tsm_pkg::tsm_reading_type int_v,
    input wire tsm_pkg::tsm_reading_type ext_v,
    input wire tsm_pkg::tsm_reading_type sup_v,
    // converter side
    output logic                 meas_valid,
    output tsm_pkg::tsm_reading_type int_temp,
    output tsm_pkg::tsm_reading_type ext_temp,
    output tsm_pkg::tsm_reading_type supply
);
    import tsm_pkg::*;
    // off the pulse the lines show the inverse, so a stray capture shows up
    always_ff @(posedge aclk) begin
        meas_valid <= go;
        int_temp   <= go ? int_v : ~int_v;
        ext_temp   <= go ? ext_v : ~ext_v;
        supply     <= go ? sup_v : ~sup_v;
    end
endmodule : tsm_sensor_model
`default_nettype wire
